// ---- pkg/vrlsm_pkg.sv ----
// Constants, register map and state codes of the video link status monitor
`default_nettype none
package vrlsm_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int HPD_MAX_NS = 1000;
  localparam int HPD_MAX_CYC = HPD_MAX_NS / CLK_PERIOD_NS;
  localparam int LOCK_REL_MAX_NS = 10000;
  localparam int LOCK_REL_MAX_CYC = LOCK_REL_MAX_NS / CLK_PERIOD_NS;
  localparam int LOCK_MAX_MS = 10;
  localparam int LOCK_MAX_CYC = LOCK_MAX_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CLK_LOCK_MAX_MS = 10;
  localparam int CLK_LOCK_MAX_CYC = CLK_LOCK_MAX_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W = 18;
  // Pixel framing
  localparam logic [2:0] SLOT_LAST = 3'h6;
  localparam int LAT_MAX = 34;
  localparam logic [5:0] LAT_NORMAL = 6'h11;
  localparam logic [5:0] LAT_DIST_8B = 6'h22;
  localparam logic [5:0] LAT_DIST_10B = 6'h21;
  localparam logic [5:0] UI_8B = 6'h1e;
  localparam logic [5:0] UI_10B = 6'h28;
  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_INT_STAT = 4'h8;
  localparam logic [3:0] OFS_INT_MASK = 4'hc;
  // Control fields
  localparam int CTRL_MONITOR_ENABLE = 0;
  localparam int CTRL_LANE_LO = 1;
  localparam int CTRL_LANE_HI = 2;
  localparam int CTRL_SIG_LO = 3;
  localparam int CTRL_SIG_HI = 4;
  localparam int CTRL_COL = 5;
  localparam int CTRL_MODE_BIT0 = 6;
  localparam int CTRL_FAIL_PAT = 7;
  localparam int CTRL_W = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Status fields
  localparam int STS_LOCKED = 0;
  localparam int STS_HPD = 1;
  localparam int STS_CLK_STABLE = 2;
  localparam int STS_CDR_OK = 3;
  localparam int STS_UI_LSB = 8;
  // Interrupt events
  localparam int EV_LOCK_GAIN = 0;
  localparam int EV_LOCK_LOSS = 1;
  localparam int EV_HPD_ON = 2;
  localparam int EV_TIMEOUT = 3;
  localparam int EV_W = 4;
  localparam logic [3:0] INT_RESET = 4'h0;
  // Link sequencing states
  typedef enum logic [3:0] {
    VRLSM_OFF = 4'h1,
    VRLSM_HPD = 4'h2,
    VRLSM_LOCK = 4'h4,
    VRLSM_SPARE = 4'h8
  } vrlsm_state_e;
endpackage
`default_nettype wire

// ---- verilog/vrlsm_top.sv ----
// Link status sequencing, LVDS framing and debug monitor of the video receiver
// Overview of operation
// R1 - Monitor off: debug pin keeps normal function
// R2 - Lane select picks monitored lane 0..3
// R3 - Signal select routes DE, HSYNC, VSYNC, clock
// R4 - Lane carries 30 or 40 UI per period
// R5 - LVDS bits sent 1,0,6,5,4,3,2 per period
// R6 - Fixed latency 17, 34 or 33 periods
// R7 - Hot-plug pulled low within 1 us
// R8 - Hot-plug released within 1 us
// R9 - Lock achieved within 10 ms of training
// R10 - Lock line released within 10 us
// R11 - LVDS clock stable within 10 ms
// R12 - Sender keeps DE intervals 8 or 16 periods
// R13 - Fail pattern drives low data when unlocked
// R14 - Destination absorbs latency differences between receivers
// R15 - Monitoring leaves every other function unchanged
// R16 - Lock line released unlocked, pulled low locked
// R17 - Sender trains until lock line goes low
// R18 - Selection re-evaluated live, no power-down needed
`timescale 1ns/1ps
`default_nettype none
module vrlsm_top #(
  parameter int LOCK_TIMEOUT_CYC = vrlsm_pkg::LOCK_MAX_CYC,
  parameter int CLK_SETTLE_CYC = vrlsm_pkg::CLK_LOCK_MAX_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Link side
  input wire logic power_down_bar,
  input wire logic [3:0] lane_train_ok,
  input wire logic [3:0] lane_de,
  input wire logic [3:0] lane_hsync,
  input wire logic [3:0] lane_vsync,
  input wire logic [3:0] lane_clk,
  input wire logic normal_debug_in,
  // Open-drain and shared pins
  output logic hot_plug_bar_o,
  output logic hot_plug_bar_oe_n,
  output logic lock_bar_o,
  output logic lock_bar_oe_n,
  input wire logic shared_lock_bus_i,
  output logic shared_lock_bus_o,
  output logic shared_lock_bus_oe_n,
  // Debug and LVDS side
  output logic debug_output_pin,
  output logic [3:0] lvds_c_serial,
  output logic lvds_oe_n,
  output logic lvds_clk_stable,
  output logic irq
);
  localparam int HPD_A_MAX = 25;

  // Serial slot to word bit: 1,0,6,5,4,3,2
  function automatic logic [2:0] slot_bit(input logic [2:0] slot);
    case (slot)
      3'h0: slot_bit = 3'h1;
      3'h1: slot_bit = 3'h0;
      default: slot_bit = 3'h0 - slot; // Eight minus slot, modulo eight
    endcase
  endfunction

  // Pipeline depth from mode and colour depth
  function automatic logic [5:0] lat_depth(input logic mode_bit0, input logic col);
    if (!mode_bit0) begin
      lat_depth = vrlsm_pkg::LAT_NORMAL;
    end else begin
      lat_depth = col ? vrlsm_pkg::LAT_DIST_10B : vrlsm_pkg::LAT_DIST_8B;
    end
  endfunction

  logic [7:0] ctrl, next_ctrl;
  logic [3:0] int_stat, next_int_stat;
  logic [3:0] int_mask, next_int_mask;
  logic wr_pend, next_wr_pend;
  logic [3:0] wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;
  logic [31:0] status_word;
  logic [3:0] ev;
  logic acc;
  vrlsm_pkg::vrlsm_state_e state, next_state;
  logic [17:0] cnt, next_cnt;
  logic [17:0] clk_cnt, next_clk_cnt;
  logic clk_ok, next_clk_ok;
  logic cdr_ok;
  logic [2:0] slot, next_slot;
  logic [11:0] pipe [0:33];
  logic [11:0] next_pipe [0:33];
  logic [6:0] word [0:3];
  logic [6:0] next_word [0:3];
  logic [3:0] next_serial;
  logic next_debug;
  logic [11:0] pipe_out;
  logic [1:0] lane_sel, sig_sel;
  logic locked;

  assign cdr_ok = &lane_train_ok;
  assign locked = (state == vrlsm_pkg::VRLSM_LOCK);
  assign lane_sel = ctrl[vrlsm_pkg::CTRL_LANE_HI:vrlsm_pkg::CTRL_LANE_LO];
  assign sig_sel = ctrl[vrlsm_pkg::CTRL_SIG_HI:vrlsm_pkg::CTRL_SIG_LO];

  // Bus handshake: zero wait, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign acc = hsel & htrans[1] & hready;

  // Status word and interrupt line
  always_comb begin
    status_word = 32'h0;
    status_word[vrlsm_pkg::STS_LOCKED] = locked;
    status_word[vrlsm_pkg::STS_HPD] = ~hot_plug_bar_oe_n;
    status_word[vrlsm_pkg::STS_CLK_STABLE] = clk_ok;
    status_word[vrlsm_pkg::STS_CDR_OK] = cdr_ok;
    status_word[vrlsm_pkg::STS_UI_LSB +: 6] = ctrl[vrlsm_pkg::CTRL_COL] ?
      vrlsm_pkg::UI_10B : vrlsm_pkg::UI_8B; // R4
  end
  assign irq = |(int_stat & int_mask);

  // Register file next values
  always_comb begin
    next_ctrl = ctrl;
    next_int_mask = int_mask;
    next_int_stat = int_stat | ev; // Set wins over clear
    next_wr_pend = acc & hwrite;
    next_wr_addr = acc ? haddr[3:0] : wr_addr;
    next_hrdata = hrdata;
    if (wr_pend) begin
      case (wr_addr)
        vrlsm_pkg::OFS_CTRL: next_ctrl = hwdata[7:0];
        vrlsm_pkg::OFS_INT_STAT: next_int_stat = (int_stat & ~hwdata[3:0]) | ev;
        vrlsm_pkg::OFS_INT_MASK: next_int_mask = hwdata[3:0];
        default: next_ctrl = ctrl;
      endcase
    end
    if (acc && !hwrite) begin
      case (haddr[3:0])
        vrlsm_pkg::OFS_CTRL: next_hrdata = {24'h0, ctrl};
        vrlsm_pkg::OFS_STATUS: next_hrdata = status_word;
        vrlsm_pkg::OFS_INT_STAT: next_hrdata = {28'h0, int_stat};
        vrlsm_pkg::OFS_INT_MASK: next_hrdata = {28'h0, int_mask};
        default: next_hrdata = 32'h0;
      endcase
    end
  end

  // Register file storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= vrlsm_pkg::CTRL_RESET;
      int_stat <= vrlsm_pkg::INT_RESET;
      int_mask <= vrlsm_pkg::INT_RESET;
      wr_pend <= 1'b0;
      wr_addr <= 4'h0;
      hrdata <= 32'h0;
    end else begin
      ctrl <= next_ctrl;
      int_stat <= next_int_stat;
      int_mask <= next_int_mask;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
    end
  end

  // Link sequencing next values
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_clk_cnt = clk_cnt;
    next_clk_ok = clk_ok;
    ev = 4'h0;
    case (state)
      vrlsm_pkg::VRLSM_OFF: begin
        next_cnt = 18'h0;
        if (power_down_bar) begin
          next_state = vrlsm_pkg::VRLSM_HPD; // R7
          ev[vrlsm_pkg::EV_HPD_ON] = 1'b1;
        end
      end
      vrlsm_pkg::VRLSM_HPD: begin
        next_cnt = cnt + 18'h1;
        if (cdr_ok && shared_lock_bus_i) begin
          next_state = vrlsm_pkg::VRLSM_LOCK; // R9
          ev[vrlsm_pkg::EV_LOCK_GAIN] = 1'b1;
          next_cnt = 18'h0;
        end else if (cnt == 18'(LOCK_TIMEOUT_CYC - 1)) begin
          ev[vrlsm_pkg::EV_TIMEOUT] = 1'b1; // R9
          next_cnt = 18'h0;
        end
      end
      vrlsm_pkg::VRLSM_LOCK: begin
        if (!cdr_ok || !shared_lock_bus_i) begin
          next_state = vrlsm_pkg::VRLSM_HPD; // R16
          ev[vrlsm_pkg::EV_LOCK_LOSS] = 1'b1;
        end
      end
      default: next_state = vrlsm_pkg::VRLSM_OFF;
    endcase
    if (!power_down_bar) begin
      next_state = vrlsm_pkg::VRLSM_OFF; // R8 R10
      // Power-down out of lock counts as a lock loss
      if (state == vrlsm_pkg::VRLSM_LOCK) begin
        ev[vrlsm_pkg::EV_LOCK_LOSS] = 1'b1; // R16
      end
    end
    // LVDS clock settle after lock
    if (next_state != vrlsm_pkg::VRLSM_LOCK) begin
      next_clk_cnt = 18'h0;
      next_clk_ok = 1'b0;
    end else if (!clk_ok) begin
      next_clk_cnt = clk_cnt + 18'h1;
      next_clk_ok = (clk_cnt == 18'(CLK_SETTLE_CYC - 1)); // R11
    end
  end

  // Link sequencing storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= vrlsm_pkg::VRLSM_OFF;
      cnt <= 18'h0;
      clk_cnt <= 18'h0;
      clk_ok <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      clk_cnt <= next_clk_cnt;
      clk_ok <= next_clk_ok;
    end
  end

  // Open-drain pins: enable low pulls the wire low
  assign hot_plug_bar_o = 1'b0;
  assign hot_plug_bar_oe_n = (state == vrlsm_pkg::VRLSM_OFF); // R7 R8
  assign lock_bar_o = 1'b0;
  assign lock_bar_oe_n = ~locked; // R16
  assign shared_lock_bus_o = 1'b0;
  assign shared_lock_bus_oe_n = cdr_ok;
  assign lvds_clk_stable = clk_ok;
  assign lvds_oe_n = ~(locked | ctrl[vrlsm_pkg::CTRL_FAIL_PAT]); // R13
  assign pipe_out = pipe[lat_depth(ctrl[vrlsm_pkg::CTRL_MODE_BIT0],
    ctrl[vrlsm_pkg::CTRL_COL]) - 6'h1]; // R6

  // Pixel framing, latency line, serializer and debug mux
  always_comb begin
    next_slot = (slot == vrlsm_pkg::SLOT_LAST) ? 3'h0 : slot + 3'h1;
    for (int i = 0; i < vrlsm_pkg::LAT_MAX; i++) begin
      next_pipe[i] = pipe[i];
    end
    for (int z = 0; z < 4; z++) begin
      next_word[z] = word[z];
    end
    if (slot == vrlsm_pkg::SLOT_LAST) begin
      next_pipe[0] = {lane_de, lane_vsync, lane_hsync};
      for (int i = 1; i < vrlsm_pkg::LAT_MAX; i++) begin
        next_pipe[i] = pipe[i-1]; // R6
      end
      for (int z = 0; z < 4; z++) begin
        next_word[z] = {pipe_out[8+z], pipe_out[4+z], pipe_out[z], 4'h0};
      end
    end
    for (int z = 0; z < 4; z++) begin
      next_serial[z] = locked & word[z][slot_bit(slot)]; // R5 R13 R15
    end
    if (!ctrl[vrlsm_pkg::CTRL_MONITOR_ENABLE]) begin
      next_debug = normal_debug_in; // R1
    end else begin
      case (sig_sel) // R2 R3 R18
        2'h0: next_debug = lane_de[lane_sel];
        2'h1: next_debug = lane_hsync[lane_sel];
        2'h2: next_debug = lane_vsync[lane_sel];
        default: next_debug = lane_clk[lane_sel];
      endcase
    end
  end

  // Pixel path storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot <= 3'h0;
      for (int i = 0; i < vrlsm_pkg::LAT_MAX; i++) begin
        pipe[i] <= 12'h0;
      end
      for (int z = 0; z < 4; z++) begin
        word[z] <= 7'h0;
      end
      lvds_c_serial <= 4'h0;
      debug_output_pin <= 1'b0;
    end else begin
      slot <= next_slot;
      for (int i = 0; i < vrlsm_pkg::LAT_MAX; i++) begin
        pipe[i] <= next_pipe[i];
      end
      for (int z = 0; z < 4; z++) begin
        word[z] <= next_word[z];
      end
      lvds_c_serial <= next_serial;
      debug_output_pin <= next_debug;
    end
  end

  // Power-up sequence: rising power-down-bar then hot-plug pulled
  sequence pdb_rise_s;
    $rose(power_down_bar);
  endsequence
  sequence hpd_pulled_s;
    ##[1:HPD_A_MAX] !hot_plug_bar_oe_n;
  endsequence
  hpd_pull_a: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    pdb_rise_s |-> hpd_pulled_s) else $error("hot-plug not pulled low in time");
  hpd_release_a: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    !power_down_bar |=> hot_plug_bar_oe_n) else $error("hot-plug not released");
  lock_release_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    !power_down_bar |=> lock_bar_oe_n && !lvds_clk_stable) else $error("lock not released");
  lock_follow_a: assert property (@(posedge hclk) disable iff (!hresetn) // R16
    !cdr_ok |=> lock_bar_oe_n) else $error("lock held while cdr unlocked");
  lock_gain_a: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    (power_down_bar && cdr_ok && shared_lock_bus_i && !hot_plug_bar_oe_n)
    |=> !lock_bar_oe_n) else $error("lock not achieved");
  clk_settle_a: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    (locked && power_down_bar && cdr_ok && shared_lock_bus_i && !clk_ok &&
    clk_cnt == 18'(CLK_SETTLE_CYC - 1)) |=> lvds_clk_stable)
    else $error("lvds clock not stable in time");
  mon_off_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    !ctrl[vrlsm_pkg::CTRL_MONITOR_ENABLE] |=> debug_output_pin == $past(normal_debug_in))
    else $error("debug pin lost normal function");
  mon_clk_a: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    (ctrl[vrlsm_pkg::CTRL_MONITOR_ENABLE] && sig_sel == 2'h3)
    |=> debug_output_pin == $past(lane_clk[lane_sel])) else $error("clock not routed");
  mon_de_a: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    (ctrl[vrlsm_pkg::CTRL_MONITOR_ENABLE] && sig_sel == 2'h0 && lane_sel == 2'h2)
    |=> debug_output_pin == $past(lane_de[2])) else $error("wrong lane monitored");
  ser_order_a: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    (slot == 3'h0 && locked) |=> lvds_c_serial[0] == $past(word[0][1]))
    else $error("serial bit order wrong");
  fail_low_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    (!locked && ctrl[vrlsm_pkg::CTRL_FAIL_PAT]) |-> !lvds_oe_n
    ##1 (lvds_c_serial == 4'h0)) else $error("fail pattern not low data");
  set_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev[0] && wr_pend && wr_addr == vrlsm_pkg::OFS_INT_STAT) |=> int_stat[0])
    else $error("event lost on clear");
endmodule
`default_nettype wire

// ---- testbench/vrlsm_tx_model.sv ----
// Upstream transmitter model driving the recovered lane signals
`timescale 1ns/1ps
`default_nettype none
module vrlsm_tx_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link line and bench control
  input wire logic hot_plug_bar,
  input wire logic train_en,
  input wire logic hold,
  input wire logic [2:0] hold_val,
  // Recovered lane signals
  output logic [3:0] lane_train_ok,
  output logic [3:0] lane_de,
  output logic [3:0] lane_hsync,
  output logic [3:0] lane_vsync,
  output logic [3:0] lane_clk
);
  logic [8:0] cnt;
  // Trains once hot-plug is pulled; sends video with long DE phases from reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 9'h000;
      lane_train_ok <= 4'h0;
      lane_de <= 4'h0;
      lane_hsync <= 4'h0;
      lane_vsync <= 4'h0;
      lane_clk <= 4'h0;
    end else begin
      cnt <= cnt + 9'h001;
      lane_train_ok <= {4{train_en & ~hot_plug_bar}};
      lane_clk <= {cnt[0], ~cnt[0], cnt[1], ~cnt[1]};
      if (hold) begin
        lane_de <= {4{hold_val[2]}};
        lane_vsync <= {4{hold_val[1]}};
        lane_hsync <= {4{hold_val[0]}};
      end else begin
        lane_de <= {4{cnt[7]}} ^ 4'h5;
        lane_vsync <= cnt[8:5];
        lane_hsync <= cnt[4:1];
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/video_rx_link_status_monitor_tb_top.sv ----
// Self-checking bench of the video link status monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WT(c, n) begin k = 0; while (!(c) && k <= (n)) begin \
  @(negedge hclk); k++; end end
module video_rx_link_status_monitor_tb_top;
  localparam int LOCK_TO = 20;
  localparam int SETTLE = 8;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic power_down_bar = 1'b0;
  logic normal_debug_in = 1'b0;
  logic train_en = 1'b1;
  logic hold = 1'b0;
  logic [2:0] hold_val = 3'h0;
  logic hreadyout, hresp, hot_plug_bar_o, hot_plug_bar_oe_n, lock_bar_o, lock_bar_oe_n;
  logic shared_lock_bus_o, shared_lock_bus_oe_n, debug_output_pin, lvds_oe_n;
  logic lvds_clk_stable, irq, exp_dbg;
  logic [31:0] hrdata, rd;
  logic [3:0] lvds_c_serial, tr_ok, de, hs, vs, ck;
  logic [7:0] ctrl_sh = 8'h00;
  int err_count = 0;
  int n_compared = 0;
  int k;
  // Open-drain lines with pull-ups
  wire hpb = hot_plug_bar_oe_n ? 1'b1 : hot_plug_bar_o;
  wire slb = shared_lock_bus_oe_n ? 1'b1 : shared_lock_bus_o;

  always #20 hclk = ~hclk;

  vrlsm_top #(.LOCK_TIMEOUT_CYC(LOCK_TO), .CLK_SETTLE_CYC(SETTLE)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .power_down_bar(power_down_bar), .lane_train_ok(tr_ok), .lane_de(de),
    .lane_hsync(hs), .lane_vsync(vs), .lane_clk(ck), .normal_debug_in(normal_debug_in),
    .hot_plug_bar_o(hot_plug_bar_o), .hot_plug_bar_oe_n(hot_plug_bar_oe_n),
    .lock_bar_o(lock_bar_o), .lock_bar_oe_n(lock_bar_oe_n), .shared_lock_bus_i(slb),
    .shared_lock_bus_o(shared_lock_bus_o), .shared_lock_bus_oe_n(shared_lock_bus_oe_n),
    .debug_output_pin(debug_output_pin), .lvds_c_serial(lvds_c_serial),
    .lvds_oe_n(lvds_oe_n), .lvds_clk_stable(lvds_clk_stable), .irq(irq));

  vrlsm_tx_model tx (
    .hclk(hclk), .hresetn(hresetn), .hot_plug_bar(hpb), .train_en(train_en),
    .hold(hold), .hold_val(hold_val), .lane_train_ok(tr_ok), .lane_de(de),
    .lane_hsync(hs), .lane_vsync(vs), .lane_clk(ck));

  // Expected debug pin value from the selection and the lanes
  function automatic logic dbg_of(input logic [7:0] c, input logic nd);
    logic [3:0] s;
    s = (c[4:3] == 2'h0) ? de : (c[4:3] == 2'h1) ? hs : (c[4:3] == 2'h2) ? vs : ck;
    return c[0] ? s[c[2:1]] : nd;
  endfunction

  // Expected latency in output periods
  function automatic int lat_of(input logic col, input logic md);
    return !md ? 17 : (col ? 33 : 34);
  endfunction

  // True when the 7-bit frame is a rotation of the DE and VSYNC pattern
  function automatic logic rot_ok(input logic [6:0] v);
    logic [13:0] d;
    d = {v, v};
    rot_ok = 1'b0;
    for (int i = 0; i < 7; i++) if (d[i +: 7] == 7'b0001100) rot_ok = 1'b1;
  endfunction

  // Debug pin expectation registered on the same clock edge as the design
  always @(posedge hclk) exp_dbg <= dbg_of(ctrl_sh, normal_debug_in);

  // Single AHB-Lite transfer, read data kept in rd
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, {28'h0, a}, 32'h0);
    `CHK(rd & m, e)
  endtask

  // Sets the selection and follows the debug pin for a while
  task automatic mon(input logic [7:0] c);
    bus(1'b1, 32'h0, {24'h0, c});
    ctrl_sh = c;
    repeat (3) @(posedge hclk);
    repeat (12) begin
      @(posedge hclk);
      normal_debug_in <= 1'($urandom);
      @(negedge hclk);
      `CHK(debug_output_pin, exp_dbg)
    end
    `CHK(lock_bar_oe_n, 1'b0)
  endtask

  // Frame shape and delay from a held DE to its end on link 0
  // Panel side accepts any latency in the window of each mode
  task automatic lat(input logic col, input logic md);
    logic [6:0] v;
    int last;
    bus(1'b1, 32'h0, {24'h0, 1'b0, md, col, 5'h00});
    hold <= 1'b1;
    hold_val <= 3'h6;
    repeat (300) @(posedge hclk);
    for (int i = 0; i < 7; i++) begin
      @(negedge hclk);
      v[i] = lvds_c_serial[0];
    end
    `CHK(rot_ok(v), 1'b1)
    @(posedge hclk);
    hold_val <= 3'h0;
    last = 0;
    for (int i = 1; i < 400; i++) begin
      @(negedge hclk);
      if (lvds_c_serial[0] === 1'b1) last = i;
    end
    k = 7 * lat_of(col, md);
    `CHK(last >= k - 7 && last <= k + 21, 1'b1)
    hold <= 1'b0;
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'hd456));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    `CHK({hot_plug_bar_oe_n, lock_bar_oe_n, lvds_oe_n, irq}, 4'he)
    rchk(vrlsm_pkg::OFS_INT_MASK, 32'hf, 32'h0);
    @(posedge hclk);
    power_down_bar <= 1'b1;
    `WT(hot_plug_bar_oe_n === 1'b0, vrlsm_pkg::HPD_MAX_CYC)
    `CHK(hot_plug_bar_oe_n, 1'b0)
    `WT(lock_bar_oe_n === 1'b0, LOCK_TO)
    `CHK(lock_bar_oe_n, 1'b0)
    `WT(lvds_clk_stable === 1'b1, SETTLE + 2)
    `CHK(lvds_clk_stable, 1'b1)
    rchk(vrlsm_pkg::OFS_STATUS, 32'h3f0f, {18'h0, vrlsm_pkg::UI_8B, 8'h0f});
    rchk(vrlsm_pkg::OFS_INT_STAT, 32'hf, 32'h5);
    `CHK(irq, 1'b0)
    bus(1'b1, 32'hc, 32'h1);
    @(negedge hclk);
    `CHK(irq, 1'b1)
    bus(1'b1, 32'h8, 32'h1);
    @(negedge hclk);
    `CHK(irq, 1'b0)
    for (int i = 0; i < 16; i++) mon({3'h0, i[3:2], i[1:0], 1'b1});
    repeat (6) mon(8'($urandom) & 8'h1e);
    repeat (6) mon(8'($urandom) | 8'h01);
    bus(1'b1, 32'h0, 32'h20);
    rchk(vrlsm_pkg::OFS_STATUS, 32'h3f00, {18'h0, vrlsm_pkg::UI_10B, 8'h00});
    for (int i = 0; i < 3; i++) lat(i == 2, i > 0);
    @(posedge hclk);
    power_down_bar <= 1'b0;
    `WT(hot_plug_bar_oe_n === 1'b1, vrlsm_pkg::HPD_MAX_CYC)
    `CHK(hot_plug_bar_oe_n, 1'b1)
    `WT(lock_bar_oe_n === 1'b1, vrlsm_pkg::LOCK_REL_MAX_CYC)
    `CHK(lock_bar_oe_n, 1'b1)
    rchk(vrlsm_pkg::OFS_INT_STAT, 32'h2, 32'h2);
    bus(1'b1, 32'h0, 32'h80);
    @(negedge hclk);
    `CHK({lvds_oe_n, lvds_c_serial}, 5'h00)
    bus(1'b1, 32'h0, 32'h0);
    @(negedge hclk);
    `CHK(lvds_oe_n, 1'b1)
    train_en <= 1'b0;
    @(posedge hclk);
    power_down_bar <= 1'b1;
    repeat (LOCK_TO + 10) @(posedge hclk);
    rchk(vrlsm_pkg::OFS_INT_STAT, 32'h9, 32'h8);
    bus(1'b1, 32'hc, 32'h8);
    @(negedge hclk);
    `CHK(irq, 1'b1)
    results();
  end

  // Watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    results();
  end
endmodule
`default_nettype wire
